//--- verilog/lun_status_regs.svh
// Register offsets, field positions, opcodes and reset values of the unit status block
`ifndef LUN_STATUS_REGS_SVH
`define LUN_STATUS_REGS_SVH

// ****************************************
// Geometry
// ****************************************
`define LS_NUM_PLANES        4
`define LS_PLANE_AW          2

// ****************************************
// Register byte offsets
// ****************************************
`define LS_OFF_CTRL          12'h000
`define LS_OFF_UNIT_STATUS   12'h004
`define LS_OFF_IRQ_STATUS    12'h008
`define LS_OFF_IRQ_MASK      12'h00C
`define LS_OFF_STATE         12'h010

// ****************************************
// Control fields
// ****************************************
`define LS_CTRL_INTERLEAVE   0
`define LS_CTRL_RESUME_LO    1
`define LS_CTRL_RESUME_HI    2
`define LS_CTRL_CONFIRM_LO   8
`define LS_CTRL_CONFIRM_HI   15

// ****************************************
// Interrupt event bits
// ****************************************
`define LS_IRQ_RETURNED      0
`define LS_IRQ_DESELECTED    1
`define LS_IRQ_OUTPUT_OFF    2
`define LS_IRQ_W             3

// ****************************************
// Opcodes
// ****************************************
`define LS_OP_STATUS         8'h70
`define LS_OP_STATUS_ENH     8'h78
`define LS_OP_READ_A         8'h30
`define LS_OP_READ_B         8'h31
`define LS_OP_READ_C         8'h32
`define LS_OP_READ_D         8'h35

// ****************************************
// Reset values
// ****************************************
`define LS_RST_CTRL          32'h0000_0000
`define LS_RST_UNIT_STATUS   8'hE0
`define LS_RST_OPCODE        8'h00
`define LS_RST_FAIL          2'h0

`endif

//--- verilog/lun_status_pkg.sv
// Types shared by the unit status block
package lun_status_pkg;

    // ****************************************
    // State and mode types
    // ****************************************
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_IDLE_RD,
        ST_EXECUTE,
        ST_VALUE,
        ST_ENHANCED,
        ST_LEGACY,
        ST_MPL_COMP,
        ST_MPL_ADDR,
        ST_UNIT,
        ST_RESUME,
        ST_OUTPUT_OFF
    } state_t;

    typedef enum logic [1:0] {
        RES_IDLE,
        RES_IDLE_RD,
        RES_HANDBACK
    } resume_t;

    typedef enum logic [1:0] {
        KIND_VALUE,
        KIND_ENHANCED,
        KIND_LEGACY
    } req_kind_t;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic       status_req;
        logic       cmd_valid;
        logic [7:0] cmd_code;
        logic       row_selects_unit;
        logic [1:0] plane_addr;
        logic       out_off_req;
        logic       reset_done;
    } target_req_t;

    typedef struct packed {
        logic       valid;
        logic [1:0] plane;
        logic [1:0] bits;
    } fail_event_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } status_resp_t;

    typedef struct packed {
        logic       interleave_active;
        resume_t    resume_state;
        logic [7:0] last_confirm_opcode;
        logic [7:0] unit_status_reg;
    } ctrl_t;

endpackage

//--- verilog/plane_fail_store.sv
// Per-plane failure records and the status words built from them
`timescale 1ns/10ps
`include "lun_status_regs.svh"

module plane_fail_store (
    // Clock and reset
    input  wire logic                       i_clock,
    input  wire logic                       i_rst_b,
    // Record updates
    input  wire lun_status_pkg::fail_event_t i_fail,
    input  wire logic                       i_clear,
    // Status composition
    input  wire logic [7:0]                 i_unit_status,
    input  wire logic [1:0]                 i_plane_addr,
    output logic [7:0]                      o_mpl_word,
    output logic [7:0]                      o_addr_word
);
    import lun_status_pkg::*;

    logic [1:0] plane_fail_bits [`LS_NUM_PLANES];
    logic [`LS_NUM_PLANES-1:0] fail_hi;
    logic [`LS_NUM_PLANES-1:0] fail_lo;

    // ****************************************
    // Records, set wins over clear
    // ****************************************
    genvar p;
    generate
        for (p = 0; p < `LS_NUM_PLANES; p++) begin : g_plane
            always_ff @(posedge i_clock or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    plane_fail_bits[p] <= `LS_RST_FAIL;
                end else if (i_fail.valid && i_fail.plane == p) begin
                    plane_fail_bits[p] <= i_fail.bits;
                end else if (i_clear) begin
                    plane_fail_bits[p] <= `LS_RST_FAIL;
                end
            end
            assign fail_hi[p] = plane_fail_bits[p][1];
            assign fail_lo[p] = plane_fail_bits[p][0];
        end
    endgenerate

    // ****************************************
    // Status words
    // ****************************************
    assign o_mpl_word  = {i_unit_status[7:2], |fail_hi, |fail_lo};
    assign o_addr_word = {i_unit_status[7:2], plane_fail_bits[i_plane_addr]};

endmodule

//--- verilog/lun_status_apb.sv
// APB register file and interrupt logic of the unit status block
`timescale 1ns/10ps
`include "lun_status_regs.svh"

module lun_status_apb (
    // Clock and reset
    input  wire logic                  i_clock,
    input  wire logic                  i_rst_b,
    // APB
    input  wire logic                  i_psel,
    input  wire logic                  i_penable,
    input  wire logic                  i_pwrite,
    input  wire logic [11:0]           i_paddr,
    input  wire logic [31:0]           i_pwdata,
    output logic [31:0]                o_prdata,
    output logic                       o_pready,
    output logic                       o_pslverr,
    // Block side
    input  wire logic [`LS_IRQ_W-1:0]  i_events,
    input  wire logic [15:0]           i_state_word,
    output lun_status_pkg::ctrl_t      o_ctrl,
    output logic                       o_irq
);
    import lun_status_pkg::*;

    logic [31:0]          ctrl_reg;
    logic [7:0]           unit_status_reg;
    logic [`LS_IRQ_W-1:0] irq_status_reg;
    logic [`LS_IRQ_W-1:0] irq_mask_reg;
    logic [31:0]          rdata_next;
    logic                 hit;
    logic                 wr_en;
    logic                 setup;

    assign setup    = i_psel && !i_penable;
    assign wr_en    = i_psel && i_penable && i_pwrite;
    assign o_pready = 1'b1;

    // ****************************************
    // Address decode
    // ****************************************
    always_comb begin
        hit        = 1'b1;
        rdata_next = 32'h0000_0000;
        if (i_paddr == `LS_OFF_CTRL) begin
            rdata_next = ctrl_reg;
        end else if (i_paddr == `LS_OFF_UNIT_STATUS) begin
            rdata_next = {24'h00_0000, unit_status_reg};
        end else if (i_paddr == `LS_OFF_IRQ_STATUS) begin
            rdata_next = {29'h0000_0000, irq_status_reg};
        end else if (i_paddr == `LS_OFF_IRQ_MASK) begin
            rdata_next = {29'h0000_0000, irq_mask_reg};
        end else if (i_paddr == `LS_OFF_STATE) begin
            rdata_next = {16'h0000, i_state_word};
        end else begin
            hit = 1'b0;
        end
    end

    // ****************************************
    // Read data and error
    // ****************************************
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else if (setup) begin
            o_prdata  <= i_pwrite ? 32'h0000_0000 : rdata_next;
            o_pslverr <= !hit;
        end
    end

    // ****************************************
    // Writable registers
    // ****************************************
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_reg        <= `LS_RST_CTRL;
            unit_status_reg <= `LS_RST_UNIT_STATUS;
            irq_mask_reg    <= '0;
        end else if (wr_en) begin
            if (i_paddr == `LS_OFF_CTRL) begin
                ctrl_reg <= i_pwdata & 32'h0000_FF07;
            end else if (i_paddr == `LS_OFF_UNIT_STATUS) begin
                unit_status_reg <= i_pwdata[7:0];
            end else if (i_paddr == `LS_OFF_IRQ_MASK) begin
                irq_mask_reg <= i_pwdata[`LS_IRQ_W-1:0];
            end
        end
    end

    // ****************************************
    // Sticky events, set wins over clear
    // ****************************************
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_status_reg <= '0;
        end else if (wr_en && i_paddr == `LS_OFF_IRQ_STATUS) begin
            irq_status_reg <= (irq_status_reg & ~i_pwdata[`LS_IRQ_W-1:0]) | i_events;
        end else begin
            irq_status_reg <= irq_status_reg | i_events;
        end
    end

    assign o_irq = |(irq_status_reg & irq_mask_reg);

    assign o_ctrl.interleave_active   = ctrl_reg[`LS_CTRL_INTERLEAVE];
    assign o_ctrl.resume_state        = resume_t'(ctrl_reg[`LS_CTRL_RESUME_HI:`LS_CTRL_RESUME_LO]);
    assign o_ctrl.last_confirm_opcode = ctrl_reg[`LS_CTRL_CONFIRM_HI:`LS_CTRL_CONFIRM_LO];
    assign o_ctrl.unit_status_reg     = unit_status_reg;

endmodule

//--- verilog/lun_status_fsm.sv
// Unit status state machine: status selection, composition, return and output release
//
// Contract
// - Execute routes request, 78h, 70h to states
// - Value picks multi-plane, addressed-plane or unit status
// - Multi-plane: bits 7..2 copied, 1..0 ORed
// - Legacy records 70h, then resumes
// - Unit state returns whole status, then resumes
// - Idle plus read confirm goes idle-after-read
// - Output-off drops driver; idle-after-read resumes idle
// - Per-plane failure records cleared by unit reset
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`include "lun_status_regs.svh"

module lun_status_fsm (
    // Clock and reset
    input  wire logic                          i_clock,
    input  wire logic                          i_rst_b,
    // APB
    input  wire logic                          i_psel,
    input  wire logic                          i_penable,
    input  wire logic                          i_pwrite,
    input  wire logic [11:0]                   i_paddr,
    input  wire logic [31:0]                   i_pwdata,
    output logic [31:0]                        o_prdata,
    output logic                               o_pready,
    output logic                               o_pslverr,
    // Target side
    input  wire lun_status_pkg::target_req_t   i_target,
    input  wire lun_status_pkg::fail_event_t   i_fail,
    output lun_status_pkg::status_resp_t       o_status,
    output logic                               o_out_enable,
    output logic                               o_handback,
    // Interrupt
    output logic                               o_irq
);
    import lun_status_pkg::*;

    state_t       state_reg;
    state_t       state_next;
    state_t       resume_dest;
    req_kind_t    kind_reg;
    ctrl_t        ctrl;
    logic [7:0]   saved_status_opcode;
    logic [7:0]   mpl_word;
    logic [7:0]   addr_word;
    logic         read_confirm;
    logic         status_cmd;
    logic         interleave_active;
    resume_t      resume_state;
    logic [7:0]   last_confirm_opcode;
    logic [7:0]   unit_status_reg;
    logic [`LS_IRQ_W-1:0] events;

    assign interleave_active   = ctrl.interleave_active;
    assign resume_state        = ctrl.resume_state;
    assign last_confirm_opcode = ctrl.last_confirm_opcode;
    assign unit_status_reg     = ctrl.unit_status_reg;

    // ****************************************
    // Register file
    // ****************************************
    lun_status_apb lun_status_apb_i (
        .i_clock      (i_clock),
        .i_rst_b      (i_rst_b),
        .i_psel       (i_psel),
        .i_penable    (i_penable),
        .i_pwrite     (i_pwrite),
        .i_paddr      (i_paddr),
        .i_pwdata     (i_pwdata),
        .o_prdata     (o_prdata),
        .o_pready     (o_pready),
        .o_pslverr    (o_pslverr),
        .i_events     (events),
        .i_state_word ({saved_status_opcode, 4'h0, state_reg}),
        .o_ctrl       (ctrl),
        .o_irq        (o_irq)
    );

    // ****************************************
    // Failure records
    // ****************************************
    plane_fail_store plane_fail_store_i (
        .i_clock       (i_clock),
        .i_rst_b       (i_rst_b),
        .i_fail        (i_fail),
        .i_clear       (i_target.reset_done),
        .i_unit_status (unit_status_reg),
        .i_plane_addr  (i_target.plane_addr),
        .o_mpl_word    (mpl_word),
        .o_addr_word   (addr_word)
    );

    // ****************************************
    // Decisions
    // ****************************************
    assign read_confirm = (last_confirm_opcode == `LS_OP_READ_A) ||
                          (last_confirm_opcode == `LS_OP_READ_B) ||
                          (last_confirm_opcode == `LS_OP_READ_C) ||
                          (last_confirm_opcode == `LS_OP_READ_D);

    assign status_cmd = i_target.cmd_valid &&
                        ((i_target.cmd_code == `LS_OP_STATUS) ||
                         (i_target.cmd_code == `LS_OP_STATUS_ENH));

    always_comb begin
        resume_dest = ST_IDLE;
        if (resume_state == RES_IDLE_RD) begin
            resume_dest = ST_IDLE_RD;
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE, ST_IDLE_RD: begin
                if (i_target.status_req || status_cmd) begin
                    state_next = ST_EXECUTE;
                end else if (i_target.out_off_req) begin
                    state_next = ST_OUTPUT_OFF;
                end
            end
            ST_EXECUTE: begin
                case (kind_reg)
                    KIND_ENHANCED: state_next = ST_ENHANCED;
                    KIND_LEGACY:   state_next = ST_LEGACY;
                    default:       state_next = ST_VALUE;
                endcase
            end
            ST_VALUE: begin
                if (interleave_active && saved_status_opcode == `LS_OP_STATUS) begin
                    state_next = ST_MPL_COMP;
                end else if (interleave_active &&
                             saved_status_opcode == `LS_OP_STATUS_ENH) begin
                    state_next = ST_MPL_ADDR;
                end else begin
                    state_next = ST_UNIT;
                end
            end
            ST_ENHANCED: begin
                state_next = i_target.row_selects_unit ? ST_VALUE : ST_RESUME;
            end
            ST_LEGACY, ST_MPL_COMP, ST_MPL_ADDR, ST_UNIT: begin
                state_next = ST_RESUME;
            end
            ST_RESUME: begin
                if (resume_state == RES_IDLE && read_confirm) begin
                    state_next = ST_IDLE_RD;
                end else begin
                    state_next = resume_dest;
                end
            end
            ST_OUTPUT_OFF: begin
                if (resume_state == RES_IDLE_RD) begin
                    state_next = ST_IDLE;
                end else begin
                    state_next = resume_dest;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // Request kind capture
    // ****************************************
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            kind_reg <= KIND_VALUE;
        end else if (state_reg == ST_IDLE || state_reg == ST_IDLE_RD) begin
            if (i_target.status_req) begin
                kind_reg <= KIND_VALUE;
            end else if (status_cmd && i_target.cmd_code == `LS_OP_STATUS_ENH) begin
                kind_reg <= KIND_ENHANCED;
            end else if (status_cmd) begin
                kind_reg <= KIND_LEGACY;
            end
        end
    end

    // ****************************************
    // Saved status opcode
    // ****************************************
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            saved_status_opcode <= `LS_RST_OPCODE;
        end else if (state_reg == ST_LEGACY) begin
            saved_status_opcode <= `LS_OP_STATUS;
        end else if (state_reg == ST_ENHANCED && i_target.row_selects_unit) begin
            saved_status_opcode <= `LS_OP_STATUS_ENH;
        end
    end

    // ****************************************
    // Status answer and output driver
    // ****************************************
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_status <= '0;
        end else begin
            o_status.valid <= 1'b0;
            if (state_reg == ST_MPL_COMP) begin
                o_status.valid <= 1'b1;
                o_status.data  <= mpl_word;
            end else if (state_reg == ST_MPL_ADDR) begin
                o_status.valid <= 1'b1;
                o_status.data  <= addr_word;
            end else if (state_reg == ST_UNIT) begin
                o_status.valid <= 1'b1;
                o_status.data  <= unit_status_reg;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_out_enable <= 1'b0;
        end else if (state_reg == ST_OUTPUT_OFF) begin
            o_out_enable <= 1'b0;
        end else if (state_reg inside {ST_MPL_COMP, ST_MPL_ADDR, ST_UNIT}) begin
            o_out_enable <= 1'b1;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_handback <= 1'b0;
        end else begin
            o_handback <= (state_reg == ST_RESUME || state_reg == ST_OUTPUT_OFF) &&
                          resume_state == RES_HANDBACK;
        end
    end

    assign events[`LS_IRQ_RETURNED]   = o_status.valid;
    assign events[`LS_IRQ_DESELECTED] = state_reg == ST_ENHANCED && !i_target.row_selects_unit;
    assign events[`LS_IRQ_OUTPUT_OFF] = state_reg == ST_OUTPUT_OFF;

    // ****************************************
    // Checks
    // ****************************************
    AST_EXEC_ROUTE: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (state_reg == ST_EXECUTE) |=> state_reg == ((kind_reg == KIND_ENHANCED) ? ST_ENHANCED :
            (kind_reg == KIND_LEGACY) ? ST_LEGACY : ST_VALUE))
        else $error("execute state routed wrongly");

    AST_VALUE_PICK: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (state_reg == ST_VALUE && interleave_active && saved_status_opcode == `LS_OP_STATUS)
        |=> state_reg == ST_MPL_COMP ##1 state_reg == ST_RESUME)
        else $error("multi-plane status not chosen");

    AST_MPL_WORD: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (state_reg == ST_MPL_COMP) |=> o_status.valid && o_status.data == $past(mpl_word)
        && o_status.data[7:2] == $past(unit_status_reg[7:2]))
        else $error("multi-plane status word wrong");

    AST_LEGACY_SAVE: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (state_reg == ST_LEGACY) |=> saved_status_opcode == `LS_OP_STATUS
        && state_reg == ST_RESUME && !o_status.valid)
        else $error("legacy status not recorded");

    AST_UNIT_WORD: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (state_reg == ST_UNIT) |=> o_status.valid && o_out_enable
        && o_status.data == $past(unit_status_reg))
        else $error("unit status not returned");

    AST_IDLE_READ: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (state_reg == ST_RESUME && resume_state == RES_IDLE && read_confirm)
        |=> state_reg == ST_IDLE_RD)
        else $error("idle-after-read not taken");

    AST_OUTPUT_OFF: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (state_reg == ST_OUTPUT_OFF && resume_state == RES_IDLE_RD)
        |=> !o_out_enable && state_reg == ST_IDLE)
        else $error("output driver not released");

    AST_FAIL_CLEAR: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (i_target.reset_done && !i_fail.valid) |=> mpl_word[1:0] == 2'h0)
        else $error("failure records not cleared");

    AST_ENH_DESELECT: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (state_reg == ST_ENHANCED && !i_target.row_selects_unit)
        |=> state_reg == ST_RESUME && $stable(saved_status_opcode))
        else $error("unselected unit answered enhanced status");

endmodule

//--- dv/target_model.sv
// Target-level command machine that feeds requests to the unit
`timescale 1ns/10ps

module target_model (
    // Clock
    input  wire logic                   i_clock,
    // Requests
    output lun_status_pkg::target_req_t o_req
);
    import lun_status_pkg::*;

    initial o_req = '0;

    // Levels: row selection and plane address
    task automatic level(input logic row, input logic [1:0] plane);
        @(posedge i_clock);
        o_req.row_selects_unit <= row;
        o_req.plane_addr       <= plane;
    endtask

    // One-cycle pulse: kind = {status, out off, reset done}
    task automatic send(input logic [2:0] kind, input logic [7:0] code);
        @(posedge i_clock);
        o_req.status_req  <= kind[2];
        o_req.out_off_req <= kind[1];
        o_req.reset_done  <= kind[0];
        o_req.cmd_valid   <= (code != 8'h00);
        o_req.cmd_code    <= code;
        @(posedge i_clock);
        o_req.status_req  <= 1'b0;
        o_req.out_off_req <= 1'b0;
        o_req.reset_done  <= 1'b0;
        o_req.cmd_valid   <= 1'b0;
    endtask
endmodule

//--- dv/lun_status_state_machine_test.sv
// Self-checking bench of the unit status block
`timescale 1ns/10ps

module lun_status_state_machine_test;
    import lun_status_pkg::*;
    logic clock = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, out_en, irq, hb;
    target_req_t req;
    fail_event_t fail = '0;
    status_resp_t st;
    int err_total = 0, tests_run = 0, cycles = 0;

    always #12.5 clock = ~clock;

    lun_status_fsm lun_status_fsm_i (.i_clock(clock), .i_rst_b(rst_b), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_target(req),
        .i_fail(fail), .o_status(st), .o_out_enable(out_en), .o_handback(hb), .o_irq(irq));
    target_model target_model_i (.i_clock(clock), .o_req(req));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
            err_total++;
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        psel <= 0; penable <= 0;
    endtask

    task automatic status(input logic [2:0] k, input logic [7:0] c, input logic [7:0] e);
        int n;
        target_model_i.send(k, c);
        for (n = 0; n < 12 && st.valid !== 1'b1; n++) @(posedge clock);
        chk(st.valid, 1);
        chk(st.data, e);
    endtask

    task automatic mark(input logic [1:0] p, input logic [1:0] b);
        @(posedge clock) fail <= '{1'b1, p, b};
        @(posedge clock) fail <= '0;
    endtask

    task automatic complete_run;
        $display("errors %0d checks %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            complete_run;
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (3) @(posedge clock);
        rst_b <= 1;
        apb(0, 12'h004, 0); chk(rd, 32'hE0);
        apb(0, 12'h020, 0); chk(pslverr, 1);
        apb(1, 12'h00C, 1);
        status(3'b100, 0, 8'hE0); chk(out_en, 1);
        repeat (3) @(posedge clock); chk(irq, 1);
        apb(1, 12'h008, 1); @(posedge clock); chk(irq, 0);
        // Multi-plane composition after legacy
        apb(1, 12'h004, 32'hA4); apb(1, 12'h000, 1);
        mark(1, 2'b10); mark(3, 2'b01);
        target_model_i.send(0, 8'h70); repeat (6) @(posedge clock);
        apb(0, 12'h010, 0); chk(rd[15:8], 8'h70);
        status(3'b100, 0, 8'hA7);
        // Enhanced, selected and not selected
        target_model_i.level(1, 1); status(0, 8'h78, 8'hA6);
        apb(1, 12'h008, 1);
        target_model_i.level(0, 1); target_model_i.send(0, 8'h78);
        repeat (8) @(posedge clock);
        apb(0, 12'h008, 0); chk(rd & 3, 2);
        // Records cleared by unit reset
        target_model_i.send(3'b001, 0);
        target_model_i.send(0, 8'h70); repeat (6) @(posedge clock);
        status(3'b100, 0, 8'hA4);
        // Idle-after-read, then output off
        apb(1, 12'h000, 32'h3000); status(3'b100, 0, 8'hA4);
        repeat (3) @(posedge clock);
        apb(0, 12'h010, 0); chk(rd[3:0], 1);
        target_model_i.send(3'b010, 0); repeat (3) @(posedge clock);
        chk(out_en, 0);
        apb(0, 12'h010, 0); chk(rd[3:0], 0);
        // Resume to idle-after-read, output off back to idle
        apb(1, 12'h000, 32'h2); status(3'b100, 0, 8'hA4);
        repeat (3) @(posedge clock);
        apb(0, 12'h010, 0); chk(rd[3:0], 1);
        target_model_i.send(3'b010, 0); repeat (3) @(posedge clock);
        apb(0, 12'h010, 0); chk(rd[3:0], 0);
        apb(0, 12'h008, 0); chk(rd & 4, 4);
        // Handback to a return state outside the block
        apb(1, 12'h000, 32'h4); target_model_i.send(3'b010, 0);
        repeat (2) @(posedge clock); chk(hb, 1);
        @(posedge clock); chk(hb, 0);
        complete_run;
    end
endmodule
